/* File: verilog/bsc_defines.svh */
// Constants of the blower speed select block: offsets, field positions, resets, times.
// Assumes a 20 MHz clock and a 32-bit AHB-Lite register bus.
`ifndef BSC_DEFINES_SVH
`define BSC_DEFINES_SVH

// ==========================================================================
// Register byte offsets.
`define BSC_OFF_CTRL     8'h00
`define BSC_OFF_STATUS   8'h04
`define BSC_OFF_ACTIVE   8'h08
`define BSC_OFF_AIRFLOW  8'h0c

// ==========================================================================
// Settings field positions (control and active-settings registers).
`define BSC_F_HIGH_LSB   0
`define BSC_F_LOW_LSB    3
`define BSC_F_HEAT_LSB   6
`define BSC_F_ADJ_LSB    9
`define BSC_F_STAGE_BIT  11
`define BSC_F_OFF_LSB    12
`define BSC_F_TEST_BIT   14
`define BSC_F_ZONE_BIT   15

// ==========================================================================
// Reset values of the settings.
`define BSC_RST_HIGH_TAP 3'h4
`define BSC_RST_LOW_TAP  3'h1
`define BSC_RST_HEAT_TAP 3'h1
`define BSC_RST_OFF_SEL  2'h3

// ==========================================================================
// Adjust encodings.
`define BSC_ADJ_NORM     2'h0
`define BSC_ADJ_PLUS     2'h1
`define BSC_ADJ_MINUS    2'h2

// ==========================================================================
// Times and airflow scale.
`define BSC_CLK_HZ       20000000
`define BSC_QUARTERS     4
`define BSC_FAN_ON_S     45
`define BSC_OFF0_S       90
`define BSC_OFF1_S       120
`define BSC_OFF2_S       180
`define BSC_OFF3_S       270
`define BSC_CFM_BASE_H   8'h08
`define BSC_CFM_STEP_H   8'h04
`define BSC_FLASH_ON_Q   4'h2
`define BSC_FLASH_OFF_Q  4'h2
`define BSC_HALF_ON_Q    4'h1
`define BSC_GAP_Q        4'h8

`endif

/* File: verilog/bsc_pkg.sv */
// Types shared by the blower speed select block.
// Assumes the constants header is compiled alongside.
package bsc_pkg;

    // ======================================================================
    // Settled call and status inputs from the pins.
    typedef struct packed {
        logic fan;        // Fan call.
        logic heat1;      // First stage heat call.
        logic heat2;      // Second stage heat call.
        logic dehum;      // Dehumidify speed input.
        logic limit;      // Primary limit trip, high when tripped.
        logic motor_on;   // Motor still turning.
    } bsc_pins_s;

    // Jumper settings as software writes them.
    typedef struct packed {
        logic       zoning;
        logic       test;
        logic [1:0] off_sel;
        logic       two_stage;
        logic [1:0] adjust;
        logic [2:0] heat_tap;
        logic [2:0] low_tap;
        logic [2:0] high_tap;
    } bsc_cfg_s;

    // Command to the motor.
    typedef struct packed {
        logic       run;
        logic       test;
        logic [1:0] adjust;
        logic [2:0] tap;
    } bsc_motor_s;

    // Heating sequence states.
    typedef enum logic [1:0] {ST_IDLE, ST_ON_DELAY, ST_HEAT_RUN, ST_OFF_DELAY} bsc_state_e;

    // Speed tap set in use.
    typedef enum logic [1:0] {SEL_LOW, SEL_HIGH, SEL_HEAT} bsc_sel_e;

endpackage : bsc_pkg

/* File: verilog/bsc_blower_speed_select.sv */
// Blower speed select: heat fan delays, speed tap choice, indicators, airflow flashes.
// Assumes a free-running 20 MHz clock, an AHB-Lite master and pins from other domains.
//
// Added by the designer: the register addresses and the AHB-Lite register port.
`timescale 1ns/10ps
`include "bsc_defines.svh"

// Operation
// - Hold run demand 45 s after heat call.
// - Keep run demand until fan-off delay ends.
// - Run low speed when neither high nor heat.
// - Heat indicator delayed, held through fan-off delay.
// - Speed level lit on high, dark low.
// - One flash per 100 CFM, half for 50.
// - Take new settings only with motor stopped.
// - Adjust scales speeds nominal, plus or minus 10%.
// - Test runs motor near 70% with fan call.
// - Single stage: first stage heat uses heat tap.
// - Two stage: first stage heat uses low tap.
// - Two stage: second stage heat uses heat tap.
// - Fan plus dehumidify selects high tap.
// - Fan call alone selects low tap.
// - Selectable fan-off delay, default 270 s.
// - Zoning heat capped at highest cooling speed.
// - Zoning uses heat tap only on limit trip.
// - Defaults: high 4, low 1, normal, heat 1.
// - Motor exchange between cycles may flicker display.
module bsc_blower_speed_select #(
    parameter int QSEC_CYCLES = `BSC_CLK_HZ / `BSC_QUARTERS  // Clock cycles per quarter second.
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic [31:0]            hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    input  wire bsc_pkg::bsc_pins_s pins_in,
    output bsc_pkg::bsc_motor_s    motor_cmd,
    output logic                   run_demand_indicator,
    output logic                   heat_speed_indicator,
    output logic                   speed_level_indicator,
    output logic                   airflow_flash_indicator
);
    import bsc_pkg::*;

    // ======================================================================
    // Declarations.
    localparam int ON_Q = `BSC_FAN_ON_S * `BSC_QUARTERS;  // Fan-on delay in quarter seconds.

    bsc_pins_s  sync1;        // First synchroniser stage.
    bsc_pins_s  sync2;        // Second synchroniser stage.
    bsc_pins_s  sync3;        // Third synchroniser stage.
    bsc_pins_s  p;            // Settled pin levels.
    bsc_cfg_s   cfg_req;      // Settings written by software.
    bsc_cfg_s   cfg_act;      // Settings in force.
    bsc_state_e state;        // Heating sequence state.
    bsc_sel_e   heat_sel;     // Tap set chosen for heating.
    bsc_sel_e   next_heat_sel;
    bsc_sel_e   sel;          // Tap set in use now.
    logic [22:0] qcnt;        // Quarter second prescaler.
    logic        tick;        // One-cycle quarter second pulse.
    logic [10:0] dcnt;        // Delay counter in quarter seconds.
    logic        heat_call;   // Any heat call.
    logic        heat_active; // Blower held by the heating sequence.
    logic        stopped;     // Motor fully stopped.
    logic [7:0]  airflow_h;   // Airflow in units of 50 CFM.
    logic [7:0]  flash_left;  // Halves still to be flashed.
    logic [3:0]  fcnt;        // Flash phase counter in quarter seconds.
    logic        ph_sel;      // Bus address phase accepted.
    logic        ph_write;    // Accepted phase is a write.
    logic [7:0]  ph_addr;     // Accepted byte address.

    // ======================================================================
    // Functions.
    // Fan-off delay in quarter seconds for a selection.
    function automatic logic [10:0] off_q(input logic [1:0] s);
        int secs;
        case (s)
            2'h0:    secs = `BSC_OFF0_S;
            2'h1:    secs = `BSC_OFF1_S;
            2'h2:    secs = `BSC_OFF2_S;
            default: secs = `BSC_OFF3_S;
        endcase
        return 11'(secs * `BSC_QUARTERS);
    endfunction : off_q

    // Airflow of a tap in 50 CFM units, scaled by the adjust setting.
    function automatic logic [7:0] tap_airflow(input logic [2:0] tap, input logic [1:0] adj);
        logic [7:0] nom;
        nom = `BSC_CFM_BASE_H + 8'(`BSC_CFM_STEP_H * tap);
        case (adj)
            `BSC_ADJ_PLUS:  return nom + nom / 8'd10;
            `BSC_ADJ_MINUS: return nom - nom / 8'd10;
            default:        return nom;
        endcase
    endfunction : tap_airflow

    // Tap number for a tap set.
    function automatic logic [2:0] tap_of(input bsc_sel_e s, input bsc_cfg_s c);
        case (s)
            SEL_HIGH: return c.high_tap;
            SEL_HEAT: return c.heat_tap;
            default:  return c.low_tap;
        endcase
    endfunction : tap_of

    // ======================================================================
    // Pin synchroniser: a change counts once the second and third stages agree.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
            p     <= '0;
        end else begin
            sync1 <= pins_in;
            sync2 <= sync1;
            sync3 <= sync2;
            p     <= (~(sync2 ^ sync3) & sync3) | ((sync2 ^ sync3) & p);
        end
    end

    // Quarter second prescaler, free running.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            qcnt <= '0;
        end else if (qcnt == 23'(QSEC_CYCLES - 1)) begin
            qcnt <= '0;
        end else begin
            qcnt <= qcnt + 23'd1;
        end
    end
    assign tick = (qcnt == 23'(QSEC_CYCLES - 1));

    // ======================================================================
    // Heating sequence: fan-on delay, heat run, fan-off delay.
    assign heat_call   = p.heat1 | p.heat2;
    assign heat_active = (state == ST_HEAT_RUN) || (state == ST_OFF_DELAY);

    // The delay ends one tick late so that the free prescaler never shortens it.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= ST_IDLE;
            dcnt  <= '0;
        end else begin
            case (state)
                ST_IDLE: begin
                    dcnt <= '0;
                    if (heat_call) begin
                        state <= ST_ON_DELAY;
                    end
                end
                ST_ON_DELAY: begin
                    if (!heat_call) begin
                        state <= ST_IDLE;
                    end else if (tick && dcnt == 11'(ON_Q)) begin
                        state <= ST_HEAT_RUN;
                    end else if (tick) begin
                        dcnt <= dcnt + 11'd1;
                    end
                end
                ST_HEAT_RUN: begin
                    dcnt <= '0;
                    if (!heat_call) begin
                        state <= ST_OFF_DELAY;
                    end
                end
                ST_OFF_DELAY: begin
                    if (heat_call) begin
                        state <= ST_HEAT_RUN;
                    end else if (tick && dcnt == off_q(cfg_act.off_sel)) begin
                        state <= ST_IDLE;
                    end else if (tick) begin
                        dcnt <= dcnt + 11'd1;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Tap set wanted by the present heat calls.
    always_comb begin
        next_heat_sel = SEL_HEAT;
        if (cfg_act.two_stage && !p.heat2) begin
            next_heat_sel = SEL_LOW;
        end
        if (cfg_act.zoning && next_heat_sel == SEL_HEAT && !p.limit) begin
            next_heat_sel = SEL_HIGH;
        end
    end

    // The heating tap set follows the calls and is frozen through the fan-off delay.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            heat_sel <= SEL_LOW;
        end else if (state != ST_OFF_DELAY && heat_call) begin
            heat_sel <= next_heat_sel;
        end
    end

    // Heating owns the blower; otherwise the fan call chooses high or low.
    always_comb begin
        if (heat_active) begin
            sel = heat_sel;
        end else if (p.fan && p.dehum) begin
            sel = SEL_HIGH;
        end else begin
            sel = SEL_LOW;
        end
    end

    // ======================================================================
    // Motor command and indicators.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            motor_cmd             <= '0;
            run_demand_indicator  <= 1'b0;
            heat_speed_indicator  <= 1'b0;
            speed_level_indicator <= 1'b0;
        end else if (cfg_act.test) begin
            motor_cmd.run         <= p.fan;
            motor_cmd.test        <= p.fan;
            motor_cmd.adjust      <= `BSC_ADJ_NORM;
            motor_cmd.tap         <= '0;
            run_demand_indicator  <= p.fan;
            heat_speed_indicator  <= 1'b0;
            speed_level_indicator <= 1'b0;
        end else begin
            motor_cmd.run         <= heat_active | p.fan;
            motor_cmd.test        <= 1'b0;
            // Speed requests drop with the run demand so that an idle motor sees none.
            motor_cmd.adjust      <= (heat_active | p.fan) ? cfg_act.adjust : `BSC_ADJ_NORM;
            motor_cmd.tap         <= (heat_active | p.fan) ? tap_of(sel, cfg_act) : 3'h0;
            run_demand_indicator  <= heat_active | p.fan;
            heat_speed_indicator  <= heat_active && sel == SEL_HEAT;
            speed_level_indicator <= (heat_active | p.fan) && sel == SEL_HIGH;
        end
    end

    // ======================================================================
    // Settings take effect only once the motor is fully stopped.
    assign stopped = !motor_cmd.run && !p.motor_on;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg_act <= '{zoning: 1'b0, test: 1'b0, off_sel: `BSC_RST_OFF_SEL,
                         two_stage: 1'b0, adjust: `BSC_ADJ_NORM,
                         heat_tap: `BSC_RST_HEAT_TAP, low_tap: `BSC_RST_LOW_TAP,
                         high_tap: `BSC_RST_HIGH_TAP};
        end else if (stopped) begin
            cfg_act <= cfg_req;
        end
    end

    // ======================================================================
    // Airflow flash display: two quarters on per full flash, one per half flash.
    // Between runs the new settings reach the display, so the count may jump.
    assign airflow_h = tap_airflow(tap_of(sel, cfg_act), cfg_act.adjust);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flash_left              <= '0;
            fcnt                    <= '0;
            airflow_flash_indicator <= 1'b0;
        end else if (tick) begin
            if (fcnt != 4'h0) begin
                fcnt <= fcnt - 4'h1;
            end else if (airflow_flash_indicator) begin
                airflow_flash_indicator <= 1'b0;
                fcnt <= (flash_left == 8'h0) ? `BSC_GAP_Q : `BSC_FLASH_OFF_Q - 4'h1;
            end else if (flash_left >= 8'h2) begin
                airflow_flash_indicator <= 1'b1;
                flash_left <= flash_left - 8'h2;
                fcnt <= `BSC_FLASH_ON_Q - 4'h1;
            end else if (flash_left == 8'h1) begin
                airflow_flash_indicator <= 1'b1;
                flash_left <= 8'h0;
                fcnt <= `BSC_HALF_ON_Q - 4'h1;
            end else begin
                flash_left <= airflow_h;
            end
        end
    end

    // ======================================================================
    // AHB-Lite slave: zero wait states, always OKAY.
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // Address phase capture.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ph_sel   <= 1'b0;
            ph_write <= 1'b0;
            ph_addr  <= '0;
        end else if (hready) begin
            ph_sel   <= hsel && htrans[1] && hsize == 3'h2;
            ph_write <= hwrite;
            ph_addr  <= haddr[7:0];
        end
    end

    // Control register write in the data phase.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg_req <= '{zoning: 1'b0, test: 1'b0, off_sel: `BSC_RST_OFF_SEL,
                         two_stage: 1'b0, adjust: `BSC_ADJ_NORM,
                         heat_tap: `BSC_RST_HEAT_TAP, low_tap: `BSC_RST_LOW_TAP,
                         high_tap: `BSC_RST_HIGH_TAP};
        end else if (ph_sel && ph_write && ph_addr == `BSC_OFF_CTRL) begin
            cfg_req <= hwdata[15:0];
        end
    end

    // Read data; unmapped addresses read zero.
    always_comb begin
        hrdata = '0;
        if (ph_sel && !ph_write) begin
            case (ph_addr)
                `BSC_OFF_CTRL:    hrdata = {16'h0, cfg_req};
                `BSC_OFF_STATUS:  hrdata = {24'h0, cfg_req != cfg_act, p.motor_on,
                                            airflow_flash_indicator, speed_level_indicator,
                                            heat_speed_indicator, run_demand_indicator,
                                            state};
                `BSC_OFF_ACTIVE:  hrdata = {16'h0, cfg_act};
                `BSC_OFF_AIRFLOW: hrdata = {24'h0, airflow_h};
                default:          hrdata = '0;
            endcase
        end
    end

    // ======================================================================
    // Assertions and covers.
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_on_delay_dark: assert property (
        $past(state) == ST_ON_DELAY && !$past(p.fan) && !$past(cfg_act.test)
        |-> !run_demand_indicator)
        else $error("run demand during fan-on delay");
    a_off_delay_run: assert property (
        state == ST_OFF_DELAY && !cfg_act.test |=> run_demand_indicator)
        else $error("run demand dropped during fan-off delay");
    a_low_default: assert property (
        run_demand_indicator && !heat_speed_indicator && !speed_level_indicator
        && !motor_cmd.test |-> motor_cmd.tap == $past(cfg_act.low_tap))
        else $error("low speed not commanded");
    a_heat_ind_held: assert property (
        heat_speed_indicator |-> $past(state) inside {ST_HEAT_RUN, ST_OFF_DELAY})
        else $error("heat indicator outside heating run");
    a_level_high: assert property (
        speed_level_indicator |-> motor_cmd.tap == $past(cfg_act.high_tap))
        else $error("speed level lit without high tap");
    a_cfg_frozen: assert property (
        motor_cmd.run |=> $stable(cfg_act))
        else $error("settings changed while running");
    a_test_fan: assert property (
        motor_cmd.test |-> motor_cmd.run && $past(p.fan))
        else $error("test run without fan call");
    a_heat_return: assert property (
        state == ST_OFF_DELAY && heat_call |=> state == ST_HEAT_RUN)
        else $error("returning heat call did not cancel fan-off delay");
    a_idle_dark: assert property (
        $past(state) == ST_IDLE && !$past(p.fan) |-> !run_demand_indicator
        && !heat_speed_indicator && !speed_level_indicator && !motor_cmd.run)
        else $error("outputs active with no call");

    c_off_expire:  cover property (state == ST_OFF_DELAY ##1 state == ST_IDLE);
    c_heat_return: cover property (state == ST_OFF_DELAY ##1 state == ST_HEAT_RUN);
    c_test_run:    cover property (motor_cmd.test);

endmodule : bsc_blower_speed_select

/* File: verification/bsc_motor_model.sv */
// Behavioural model of the blower motor on the far side of the block.
// Assumes the design's motor command and the bench clock and reset.
`timescale 1ns/10ps

// ==========================================================================
// Motor model
module bsc_motor_model #(
    parameter int STOP_CYC = 6  // Cycles the rotor coasts after run drops.
) (
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire bsc_pkg::bsc_motor_s motor_cmd,
    output logic                    motor_on
);
    import bsc_pkg::*;

    int coast;  // Cycles left before the rotor stands still.

    // The rotor turns at once on run and coasts down for a while after it.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            coast    <= 0;
            motor_on <= 1'b0;
        end else if (motor_cmd.run) begin
            coast    <= STOP_CYC;
            motor_on <= 1'b1;
        end else if (coast > 0) begin
            coast    <= coast - 1;
        end else begin
            motor_on <= 1'b0;
        end
    end
endmodule : bsc_motor_model

/* File: verification/bsc_blower_speed_select_bench.sv */
// Self-checking bench of the blower speed select block.
// Assumes the design, its package and header, and the motor model.
`timescale 1ns/10ps
`include "bsc_defines.svh"

// ==========================================================================
// Bench top
module bsc_blower_speed_select_bench;
    import bsc_pkg::*;

    localparam int Q = 4;             // Short quarter second for the run.
    logic clk = 0, rst = 1;           // Clock and reset.
    logic hsel = 0, hwrite = 0;       // Bus controls.
    logic [1:0] htrans = 2'h0;        // Bus transfer kind.
    logic [2:0] hsize = 3'h2;         // Bus size.
    logic [31:0] haddr = 0, hwdata = 0, hrdata;
    logic hreadyout, hresp, motor_on;
    logic fan = 0, h1 = 0, h2 = 0, dh = 0, lim = 0;  // Call pins.
    bsc_pins_s pins_in;               // Pins as the block sees them.
    bsc_motor_s motor_cmd;            // Command to the motor.
    logic run_i, heat_i, lvl_i, flash_i;
    int n_fail = 0, n_checks = 0;
    logic [31:0] seed = 32'd40, rd;   // Random state and read data.

    always #25 clk = ~clk;
    assign pins_in = {fan, h1, h2, dh, lim, motor_on};

    bsc_blower_speed_select #(.QSEC_CYCLES(Q)) i_bsc_blower_speed_select (
        .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pins_in(pins_in),
        .motor_cmd(motor_cmd), .run_demand_indicator(run_i),
        .heat_speed_indicator(heat_i), .speed_level_indicator(lvl_i),
        .airflow_flash_indicator(flash_i));

    bsc_motor_model i_bsc_motor_model (
        .clk(clk), .rst(rst), .motor_cmd(motor_cmd), .motor_on(motor_on));

    // Next value of the xorshift generator.
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    // Control word from taps, adjust, stage, test and zoning; shortest off delay.
    function automatic logic [31:0] mk(logic [2:0] hi, lo, ht, logic [1:0] adj,
                                       logic ts, tst, zn);
        return {16'h0, zn, tst, 2'h0, ts, adj, ht, lo, hi};
    endfunction : mk

    // Expected airflow in half hundreds for a tap and adjust.
    function automatic logic [31:0] af(logic [2:0] tap, logic [1:0] adj);
        int a;
        a = 8 + 4 * tap;
        if (adj == `BSC_ADJ_PLUS) a = a + a / 10;
        if (adj == `BSC_ADJ_MINUS) a = a - a / 10;
        return a;
    endfunction : af

    // Prints the counts and the verdict, then stops.
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_sim

    // Compares one value and counts the outcome.
    task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // Counts a hang and closes the run.
    task automatic hang(string name);
        n_fail++;
        $display("[ERR] %s expected done seen timeout", name);
        end_sim();
    endtask : hang

    // One single word transfer; read data is taken at the closing edge.
    task automatic ahb(logic wr, logic [31:0] a, logic [31:0] wd);
        int k;
        @(posedge clk);
        hsel <= 1; haddr <= a; htrans <= 2'h2; hwrite <= wr;
        k = 0;
        do begin @(posedge clk); k++; end while (hreadyout !== 1'b1 && k < 50);
        if (k >= 50) hang("bus");
        htrans <= 2'h0; hsel <= 0; hwdata <= wd;
        k = 0;
        do begin @(posedge clk); k++; end while (hreadyout !== 1'b1 && k < 50);
        rd = hrdata;
        if (k >= 50) hang("bus");
    endtask : ahb

    // Counts the lit cycles of one whole airflow display, gap to gap.
    task automatic flash_on(output int on);
        int lo_run, k;
        on = 0; lo_run = 0; k = 0;
        while (lo_run < 20) begin
            @(posedge clk); k++;
            lo_run = flash_i ? 0 : lo_run + 1;
            if (k > 3000) hang("flash");
        end
        while (flash_i !== 1'b1) begin
            @(posedge clk); k++;
            if (k > 3000) hang("flash");
        end
        lo_run = 0;
        while (lo_run < 20) begin
            if (flash_i) begin on++; lo_run = 0; end else lo_run++;
            @(posedge clk); k++;
            if (k > 3000) hang("flash");
        end
    endtask : flash_on

    // Waits, bounded, for the run command to reach a level; returns cycles.
    task automatic wait_run(logic v, int lim_c, output int n);
        n = 0;
        while (motor_cmd.run !== v) begin
            @(posedge clk); n++;
            if (n > lim_c) hang("run");
        end
    endtask : wait_run

    // Waits, bounded, for the rotor to stand still, then lets settings land.
    task automatic wait_stop();
        int n;
        n = 0;
        while (motor_on !== 1'b0) begin
            @(posedge clk); n++;
            if (n > 100) hang("stop");
        end
        repeat (8) @(posedge clk);
    endtask : wait_stop

    // ======================================================================
    // Main sequence
    initial begin
        logic [2:0] hi, lo, ht;
        logic [1:0] adj;
        logic [31:0] r;
        int n;
        repeat (12) @(posedge clk);
        rst <= 0;
        repeat (2) @(posedge clk);
        ahb(0, `BSC_OFF_CTRL, 0); chk("ctrl_reset", 32'h304c, rd);
        ahb(0, 32'h40, 0); chk("unmapped", 0, rd);
        fan <= 1; wait_run(1, 20, n);
        chk("fan_tap", 1, motor_cmd.tap); chk("fan_lvl", 0, lvl_i);
        dh <= 1; repeat (8) @(posedge clk);
        chk("dh_tap", 4, motor_cmd.tap); chk("dh_lvl", 1, lvl_i);
        ahb(1, `BSC_OFF_CTRL, 32'h3054); dh <= 0; repeat (8) @(posedge clk);
        chk("held_tap", 1, motor_cmd.tap);
        fan <= 0; wait_run(0, 20, n); repeat (2) @(posedge clk);
        chk("idle_out", 0, {motor_cmd, run_i, heat_i, lvl_i});
        wait_stop(); ahb(0, `BSC_OFF_ACTIVE, 0); chk("active", 32'h3054, rd);
        for (int i = 0; i < 4; i++) begin
            r = xs(); {hi, lo, ht} = r[8:0]; adj = 2'(r[31:16] % 3);
            ahb(1, `BSC_OFF_CTRL, mk(hi, lo, ht, adj, 0, 0, 0)); wait_stop();
            fan <= 1; wait_run(1, 20, n);
            chk("rnd_tap", lo, motor_cmd.tap); chk("rnd_adj", adj, motor_cmd.adjust);
            ahb(0, `BSC_OFF_AIRFLOW, 0); chk("airflow", af(lo, adj), rd);
            flash_on(n); chk("flash_on", af(lo, adj) * Q, n);
            fan <= 0; wait_run(0, 20, n); wait_stop();
        end
        h1 <= 1; repeat (700) @(posedge clk); chk("on_delay", 0, run_i);
        wait_run(1, 100, n); repeat (2) @(posedge clk);
        chk("heat_tap", ht, motor_cmd.tap); chk("heat_ind", 1, heat_i);
        h1 <= 0; repeat (200) @(posedge clk); chk("off_run", 1, run_i);
        h1 <= 1; repeat (10) @(posedge clk); h1 <= 0;
        wait_run(0, 2000, n); chk("off_len", 1, n >= 360 * Q && n <= 362 * Q + 8);
        wait_stop(); ahb(1, `BSC_OFF_CTRL, mk(hi, lo, ht, adj, 1, 0, 0)); wait_stop();
        h1 <= 1; wait_run(1, 800, n); chk("two_w1", lo, motor_cmd.tap);
        h2 <= 1; repeat (8) @(posedge clk); chk("two_w2", ht, motor_cmd.tap);
        h1 <= 0; h2 <= 0; wait_run(0, 2000, n); wait_stop();
        ahb(1, `BSC_OFF_CTRL, mk(hi, lo, ht, adj, 1, 0, 1)); wait_stop();
        h1 <= 1; h2 <= 1; wait_run(1, 800, n); chk("zone_cap", hi, motor_cmd.tap);
        lim <= 1; repeat (8) @(posedge clk); chk("zone_lim", ht, motor_cmd.tap);
        h1 <= 0; h2 <= 0; lim <= 0; wait_run(0, 2000, n); wait_stop();
        ahb(1, `BSC_OFF_CTRL, mk(hi, lo, ht, adj, 0, 1, 0)); wait_stop();
        fan <= 1; wait_run(1, 20, n); chk("test_mode", 1, motor_cmd.test);
        fan <= 0; wait_run(0, 20, n);
        end_sim();
    end
endmodule : bsc_blower_speed_select_bench
